// File: logic/its_target.sv
// i2c target port: boot-time address, byte engine, clock stretching
// assumes open-drain pads outside; the link clock oversamples scl and sda
// Overview of operation
// - hold scl low while a core request is open
// - scl is stretched only after a read address ack, a write data ack or a master ack
// - silent until the address is set at boot
// - address is 0,1,strap hi,strap lo,1,1,1
// - each strap level maps onto one bit
// - byte after address selects the command
// - acknowledge matching address by pulling sda low
// - works at standard and fast rates
module its_target
  import its_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  input  wire logic       LINK_CLK,
  input  wire logic       I2C_SCL_I,
  output logic            I2C_SCL_O,
  output logic            I2C_SCL_OE,
  input  wire logic       I2C_SDA_I,
  output logic            I2C_SDA_O,
  output logic            I2C_SDA_OE,
  input  wire logic       ADDR_STRAP_HIGH,
  input  wire logic       ADDR_STRAP_LOW,
  output logic            ADDR_READY,
  output logic [6:0]      OWN_ADDR,
  output logic            CMD_STB,
  output logic [7:0]      CMD_SEL,
  output logic [7:0]      CMD_DATA
);
  // ---------------- core domain ----------------
  logic [2:0]  csync;          // synced {strap hi, strap lo, request toggle}
  logic [7:0]  boot_cnt_r;     // settle counter after reset
  logic [7:0]  boot_cnt_nxt;
  logic        addr_ok_r;      // address fixed, port may answer
  logic        addr_ok_nxt;
  logic [6:0]  own_addr_r;     // captured target address
  logic [6:0]  own_addr_nxt;
  logic        req_q_r;        // last seen request toggle
  logic        ack_tgl_r;      // answer toggle back to the link
  logic        ack_tgl_nxt;
  logic        pend_r;         // memory access in flight
  logic        pend_nxt;
  logic [7:0]  rsp_dat_r;      // read data held for the link
  logic [7:0]  rsp_dat_nxt;
  logic        cmd_stb_r;      // write strobe toward the core
  logic        cmd_stb_nxt;
  logic [7:0]  cmd_sel_r;
  logic [7:0]  cmd_sel_nxt;
  logic [7:0]  cmd_dat_r;
  logic [7:0]  cmd_dat_nxt;
  logic        new_req;        // one-cycle pulse per link request
  logic [7:0]  mem_rdata;

  // ---------------- link domain ----------------
  logic [3:0]  lsync;          // synced {scl, sda, addr ok, answer toggle}
  logic        scl_s;
  logic        sda_s;
  logic        aok_s;
  logic        ack_s;
  logic        scl_q_r;        // previous samples for edge detect
  logic        sda_q_r;
  its_state_t  st_r;
  its_state_t  st_nxt;
  its_kind_t   kind_r;
  its_kind_t   kind_nxt;
  logic [3:0]  cnt_r;          // bit counter
  logic [3:0]  cnt_nxt;
  logic [7:0]  sh_r;           // shift register
  logic [7:0]  sh_nxt;
  logic        rnw_r;          // direction of current frame
  logic        rnw_nxt;
  logic [7:0]  sub_r;          // command selector, auto-increments
  logic [7:0]  sub_nxt;
  logic        sda_oe_r;
  logic        sda_oe_nxt;
  logic        scl_oe_r;
  logic        scl_oe_nxt;
  logic        req_tgl_r;      // request toggle to the core
  logic        req_tgl_nxt;
  its_req_t    req_r;          // held stable while a request is open
  its_req_t    req_nxt;
  logic        busy;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        match;

  // straps and the request toggle are foreign to this clock
  its_sync #(.W(3)) u_csync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .d     ({ADDR_STRAP_HIGH, ADDR_STRAP_LOW, req_tgl_r}),
    .q     (csync)
  );

  assign new_req = csync[0] ^ req_q_r;

  its_cmd_mem u_mem (
    .clk   (MCLK),
    .we    (new_req & ~req_r.rd),
    .addr  (req_r.sub[MEM_AW-1:0]),
    .wdata (req_r.dat),
    .rdata (mem_rdata)
  );

  // boot: wait, then take strap levels once and open the port
  always_comb begin
    boot_cnt_nxt = boot_cnt_r;
    addr_ok_nxt  = addr_ok_r;
    own_addr_nxt = own_addr_r;
    if (!addr_ok_r) begin
      if (boot_cnt_r == 8'(BOOT_CYC - 1)) begin
        addr_ok_nxt  = 1'b1;
        own_addr_nxt = its_addr_of(csync[2], csync[1]);
      end else begin
        boot_cnt_nxt = boot_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      boot_cnt_r <= BYTE_RST;
      addr_ok_r  <= 1'b0;
      own_addr_r <= ADDR_RST;
    end else begin
      boot_cnt_r <= boot_cnt_nxt;
      addr_ok_r  <= addr_ok_nxt;
      own_addr_r <= own_addr_nxt;
    end
  end

  // request service: fields are stable while the toggle differs
  always_comb begin
    ack_tgl_nxt = ack_tgl_r;
    pend_nxt    = 1'b0;
    rsp_dat_nxt = rsp_dat_r;
    cmd_stb_nxt = 1'b0;
    cmd_sel_nxt = cmd_sel_r;
    cmd_dat_nxt = cmd_dat_r;
    if (new_req) begin
      pend_nxt = 1'b1;
      if (!req_r.rd) begin
        // selector comes from the sub-address byte
        cmd_stb_nxt = 1'b1;
        cmd_sel_nxt = req_r.sub;
        cmd_dat_nxt = req_r.dat;
      end
    end
    if (pend_r) begin
      // memory read data valid now; answer the link
      if (req_r.rd) begin
        rsp_dat_nxt = mem_rdata;
      end
      ack_tgl_nxt = ~ack_tgl_r;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      req_q_r   <= 1'b0;
      ack_tgl_r <= 1'b0;
      pend_r    <= 1'b0;
      rsp_dat_r <= BYTE_RST;
      cmd_stb_r <= 1'b0;
      cmd_sel_r <= SUB_RST;
      cmd_dat_r <= BYTE_RST;
    end else begin
      req_q_r   <= csync[0];
      ack_tgl_r <= ack_tgl_nxt;
      pend_r    <= pend_nxt;
      rsp_dat_r <= rsp_dat_nxt;
      cmd_stb_r <= cmd_stb_nxt;
      cmd_sel_r <= cmd_sel_nxt;
      cmd_dat_r <= cmd_dat_nxt;
    end
  end

  // link pins and core flags cross into the link clock
  its_sync #(.W(4)) u_lsync (
    .clk   (LINK_CLK),
    .rst_n (RSTN),
    .d     ({I2C_SCL_I, I2C_SDA_I, addr_ok_r, ack_tgl_r}),
    .q     (lsync)
  );

  assign scl_s    = lsync[3];
  assign sda_s    = lsync[2];
  assign aok_s    = lsync[1];
  assign ack_s    = lsync[0];
  assign busy     = req_tgl_r ^ ack_s;
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  // start/stop: sda moves while scl stays high
  assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;
  // own_addr_r is static once aok_s is seen, so reading it here is safe
  assign match    = (sh_r[7:1] == own_addr_r);

  // byte engine; edge detect costs two link cycles, ample for fast mode
  always_comb begin
    st_nxt      = st_r;
    kind_nxt    = kind_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    rnw_nxt     = rnw_r;
    sub_nxt     = sub_r;
    sda_oe_nxt  = sda_oe_r;
    scl_oe_nxt  = scl_oe_r;
    req_tgl_nxt = req_tgl_r;
    req_nxt     = req_r;
    if (!aok_s) begin
      // no address yet: stay off the bus
      st_nxt     = ST_IDLE;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt     = ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_c) begin
      // also covers repeated start
      st_nxt     = ST_RECV;
      kind_nxt   = BK_ADDR;
      cnt_nxt    = 4'h0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          sda_oe_nxt = 1'b0;
        end
        ST_RECV: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BIT_LAST) begin
            if (kind_r == BK_ADDR && !match) begin
              st_nxt = ST_IDLE;
            end else begin
              // pull sda low across the ack clock
              st_nxt     = ST_ACK;
              sda_oe_nxt = 1'b1;
              if (kind_r == BK_ADDR) begin
                rnw_nxt = sh_r[0];
              end else if (kind_r == BK_SUB) begin
                sub_nxt = sh_r;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            cnt_nxt    = 4'h0;
            if (kind_r == BK_ADDR && !rnw_r) begin
              st_nxt   = ST_RECV;
              kind_nxt = BK_SUB;
            end else if (kind_r == BK_SUB) begin
              st_nxt   = ST_RECV;
              kind_nxt = BK_DATA;
            end else begin
              // read fetch or write post: stretch until the core answers
              st_nxt      = ST_STALL;
              scl_oe_nxt  = 1'b1;
              req_nxt     = '{rd: rnw_r, sub: sub_r, dat: sh_r};
              req_tgl_nxt = ~req_tgl_r;
              sub_nxt     = sub_r + 8'h01;
            end
          end
        end
        ST_STALL: begin
          if (!busy) begin
            // release scl; the master sees the rise before going on
            scl_oe_nxt = 1'b0;
            cnt_nxt    = 4'h0;
            if (rnw_r) begin
              st_nxt     = ST_SEND;
              sh_nxt     = rsp_dat_r;
              sda_oe_nxt = ~rsp_dat_r[7];
            end else begin
              st_nxt   = ST_RECV;
              kind_nxt = BK_DATA;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == SEND_LAST) begin
              sda_oe_nxt = 1'b0;   // let the master ack
              st_nxt     = ST_MACK;
            end else begin
              sda_oe_nxt = ~sh_r[6];
              sh_nxt     = {sh_r[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            sh_nxt[0] = sda_s;     // low means more wanted
          end else if (scl_fall) begin
            if (!sh_r[0]) begin
              st_nxt      = ST_STALL;
              scl_oe_nxt  = 1'b1;
              req_nxt     = '{rd: 1'b1, sub: sub_r, dat: BYTE_RST};
              req_tgl_nxt = ~req_tgl_r;
              sub_nxt     = sub_r + 8'h01;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          st_nxt     = ST_IDLE;
          sda_oe_nxt = 1'b0;
          scl_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
      st_r      <= ST_IDLE;
      kind_r    <= BK_ADDR;
      cnt_r     <= 4'h0;
      sh_r      <= BYTE_RST;
      rnw_r     <= 1'b0;
      sub_r     <= SUB_RST;
      sda_oe_r  <= 1'b0;
      scl_oe_r  <= 1'b0;
      req_tgl_r <= 1'b0;
      req_r     <= '0;
    end else begin
      scl_q_r   <= scl_s;
      sda_q_r   <= sda_s;
      st_r      <= st_nxt;
      kind_r    <= kind_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      rnw_r     <= rnw_nxt;
      sub_r     <= sub_nxt;
      sda_oe_r  <= sda_oe_nxt;
      scl_oe_r  <= scl_oe_nxt;
      req_tgl_r <= req_tgl_nxt;
      req_r     <= req_nxt;
    end
  end

  // open drain: only ever pull low
  assign I2C_SCL_O  = 1'b0;
  assign I2C_SDA_O  = 1'b0;
  assign I2C_SCL_OE = scl_oe_r;
  assign I2C_SDA_OE = sda_oe_r;
  assign ADDR_READY = addr_ok_r;
  assign OWN_ADDR   = own_addr_r;
  assign CMD_STB    = cmd_stb_r;
  assign CMD_SEL    = cmd_sel_r;
  assign CMD_DATA   = cmd_dat_r;

  // ---------------- checks ----------------
  stretch_hold_a : assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (st_r == ST_STALL && busy) |-> scl_oe_r)
    else $error("scl released while request open");

  boot_silent_a : assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    !aok_s |=> (!sda_oe_r && !scl_oe_r))
    else $error("bus driven before address set");

  addr_form_a : assert property (@(posedge MCLK) disable iff (!RSTN)
    addr_ok_r |-> (own_addr_r[6:5] == 2'h1 && own_addr_r[2:0] == 3'h7))
    else $error("fixed address bits wrong");

  strap_map_a : assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(addr_ok_r) |-> own_addr_r[4:3] == $past(csync[2:1]))
    else $error("strap levels not mapped to address");

  sub_sel_a : assert property (@(posedge MCLK) disable iff (!RSTN)
    (new_req && !req_r.rd) |=> (cmd_stb_r && cmd_sel_r == $past(req_r.sub)))
    else $error("write strobe lacks selector");

  ack_match_a : assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (aok_s && !start_c && !stop_c && st_r == ST_RECV && kind_r == BK_ADDR
     && cnt_r == BIT_LAST && scl_fall && match)
    |=> (st_r == ST_ACK && sda_oe_r) ##1 sda_oe_r)
    else $error("matching address not acknowledged");

  send_edge_a : assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (aok_s && !start_c && !stop_c && st_r == ST_SEND && scl_fall && cnt_r != SEND_LAST)
    |=> sda_oe_r == ~$past(sh_r[6]))
    else $error("read bit late on sda");

  nack_miss_a : assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (aok_s && !start_c && !stop_c && st_r == ST_RECV && kind_r == BK_ADDR
     && cnt_r == BIT_LAST && scl_fall && !match)
    |=> (st_r == ST_IDLE && !sda_oe_r))
    else $error("foreign address acknowledged");

  wr_seen_c : cover property (@(posedge MCLK) disable iff (!RSTN) cmd_stb_r);
  rd_sent_c : cover property (@(posedge LINK_CLK) disable iff (!RSTN)
    st_r == ST_SEND ##[1:1000] st_r == ST_MACK);
  stretch_c : cover property (@(posedge LINK_CLK) disable iff (!RSTN)
    $rose(scl_oe_r));
endmodule

// File: logic/its_pkg.sv
// shared constants, types and helpers for the i2c target port
// assumes a 50 mhz core clock and a separate link sampling clock
package its_pkg;
  // core clock rate
  localparam int MCLK_MHZ        = 50;
  // settle time after reset before the straps are taken
  localparam int BOOT_NS         = 2000;
  localparam int BOOT_CYC        = (BOOT_NS * MCLK_MHZ + 999) / 1000;
  // master's extra wait after scl rises, standard mode
  localparam int T_HIGH_SM_NS    = 4000;
  localparam int T_HIGH_SM_CYC   = (T_HIGH_SM_NS * MCLK_MHZ + 999) / 1000;
  // supported bus rates
  localparam int SM_RATE_KBPS    = 100;
  localparam int FM_RATE_KBPS    = 400;
  // fixed address fields: addr[6:5] and addr[2:0]
  localparam logic [1:0] ADDR_FIX_HI = 2'h1;
  localparam logic [2:0] ADDR_FIX_LO = 3'h7;
  // address value before the straps are taken
  localparam logic [6:0] ADDR_RST    = 7'h00;
  // command store geometry
  localparam int MEM_DEPTH       = 16;
  localparam int MEM_AW          = 4;
  // reset values and bit counter limits
  localparam logic [7:0] SUB_RST     = 8'h00;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] SEND_LAST   = 4'h7;

  // link engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RECV  = 3'h1,
    ST_ACK   = 3'h2,
    ST_STALL = 3'h3,
    ST_SEND  = 3'h4,
    ST_MACK  = 3'h5
  } its_state_t;

  // which byte of the frame is being received
  typedef enum logic [1:0] {
    BK_ADDR = 2'h0,
    BK_SUB  = 2'h1,
    BK_DATA = 2'h2
  } its_kind_t;

  // request passed from link to core domain
  typedef struct packed {
    logic       rd;
    logic [7:0] sub;
    logic [7:0] dat;
  } its_req_t;

  // full 7-bit target address from the two strap levels
  function automatic logic [6:0] its_addr_of(input logic hi, input logic lo);
    return {ADDR_FIX_HI, hi, lo, ADDR_FIX_LO};
  endfunction
endpackage

// File: logic/its_sync.sv
// two-flop synchroniser for a group of level signals
// assumes each bit is a level or a toggle that holds for several clocks
module its_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // first stage, read only by second stage

  // plain two-stage capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: logic/its_cmd_mem.sv
// small command store addressed by the sub-address
// assumes one access per clock; read data come out of a register
module its_cmd_mem
  import its_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata
);
  logic [7:0] mem_r [MEM_DEPTH];  // storage, no reset on purpose

  // read first in cycle, registered read of old contents
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
    rdata <= mem_r[addr];
  end
endmodule

// File: tb/its_i2c_master.sv
// behavioural i2c master that stands on the far side of the target port
// assumes the bench resolves the open-drain wires with pull-ups
module its_i2c_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  int t_low  = 1300;  // scl low phase, ns
  int t_high = 600;   // scl high phase after rise is seen, ns
  // lines released at time zero
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck   = 1'b0;
  end
  // bus rate for the next frames
  task automatic set_rate(input int lo, input int hi);
    t_low  = lo;
    t_high = hi;
  endtask
  // release scl, then wait until the wire really is high
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 8000) begin
      #5;
      n++;
    end
    if (scl !== 1'b1) stuck = 1'b1;
  endtask
  // one bit out; sda moves only well after scl fell, as hold time
  task automatic put_bit(input logic b);
    #(t_low / 2) sda_low = ~b;
    #(t_low / 2);
    rise();
    #(t_high);
    scl_low = 1'b1;
  endtask
  // one bit in, sampled mid high phase
  task automatic get_bit(output logic b);
    #(t_low / 2) sda_low = 1'b0;
    #(t_low / 2);
    rise();
    #(t_high / 2) b = sda;
    #(t_high / 2);
    scl_low = 1'b1;
  endtask
  // start from an idle bus
  task automatic start();
    sda_low = 1'b1;
    #(t_low) scl_low = 1'b1;
  endtask
  // repeated start
  task automatic rstart();
    #(t_low / 2) sda_low = 1'b0;
    #(t_low / 2);
    rise();
    #(t_high) sda_low = 1'b1;
    #(t_low) scl_low = 1'b1;
  endtask
  // stop, leaves both lines released
  task automatic stop();
    #(t_low / 2) sda_low = 1'b1;
    #(t_low / 2);
    rise();
    #(t_high) sda_low = 1'b0;
    #(t_low);
  endtask
  // byte msb first, ack is 1 when the target pulled sda low
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  // byte in, then ack, or nack on the last byte
  task automatic read_byte(output logic [7:0] d, input logic last);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(last);
  endtask
endmodule

// File: tb/its_target_bench.sv
// self-checking bench for the i2c target port
// assumes pull-ups on scl and sda; straps are static across each boot
module its_target_bench
  import its_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rstn, link_clk, hi, lo;
  wire  logic scl, sda;
  logic       scl_o, scl_oe, sda_o, sda_oe, ready, stb, m_scl, m_sda, m_stuck;
  logic [6:0] own;
  logic [7:0] sel, dat;
  logic [7:0] q_sel[$], q_dat[$];  // captured command strobes
  logic       stretch_seen, sda_seen;  // sticky flags of target activity
  logic       held_seen;  // target held scl while the master had let go
  int         n_mismatch, comparisons, cyc;
  // wired-and of both parties with pull-ups
  assign scl = ~((scl_oe & ~scl_o) | m_scl);
  assign sda = ~((sda_oe & ~sda_o) | m_sda);
  its_target u_its_target (.MCLK(mclk), .RSTN(rstn), .LINK_CLK(link_clk), .I2C_SCL_I(scl),
    .I2C_SCL_O(scl_o), .I2C_SCL_OE(scl_oe), .I2C_SDA_I(sda), .I2C_SDA_O(sda_o),
    .I2C_SDA_OE(sda_oe), .ADDR_STRAP_HIGH(hi), .ADDR_STRAP_LOW(lo), .ADDR_READY(ready),
    .OWN_ADDR(own), .CMD_STB(stb), .CMD_SEL(sel), .CMD_DATA(dat));
  its_i2c_master u_its_i2c_master (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda),
    .stuck(m_stuck));
  // core clock 20 ns, link clock 12 ns at an odd phase
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  // command capture and target activity flags
  // strobe is launched on the rising edge, so look at it mid-cycle
  always @(negedge mclk) begin
    if (stb === 1'b1) begin
      q_sel.push_back(sel);
      q_dat.push_back(dat);
    end
  end
  always @(negedge link_clk) begin
    if (scl_oe === 1'b1) stretch_seen = 1'b1;
    if (sda_oe === 1'b1) sda_seen = 1'b1;
    if (scl_oe === 1'b1 && m_scl === 1'b0) held_seen = 1'b1;
  end
  // hang guard, ceiling well above the expected ~35k cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // address byte worked out here, not from the package helper
  function automatic logic [7:0] abyte(input logic h, input logic l, input logic rd);
    return {1'h0, 1'h1, h, l, 3'h7, rd};
  endfunction
  // reset for 12 cycles with the given straps
  task automatic boot(input logic h, input logic l);
    @(negedge mclk);
    hi = h;
    lo = l;
    rstn = 1'b0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < BOOT_CYC + 50) begin
      @(negedge mclk);
      n++;
    end
    chk(ready === 1'b1, "address never became ready");
    repeat (60) @(negedge mclk);
  endtask
  // a fast frame right after reset, while the address is not yet set
  task automatic t_early();
    logic a;
    boot(1'h1, 1'h0);
    stretch_seen = 1'b0;
    sda_seen = 1'b0;
    u_its_i2c_master.set_rate(100, 60);
    u_its_i2c_master.start();
    u_its_i2c_master.write_byte(abyte(1'h1, 1'h0, 1'h0), a);
    chk(ready === 1'b0 && own === ADDR_RST, "address set too early");
    u_its_i2c_master.stop();
    chk(a === 1'b0 && sda_seen === 1'b0, "answered before boot");
    chk(stretch_seen === 1'b0, "stretched before boot");
  endtask
  // every strap pair: address value, ack on match, silence on mismatch
  task automatic t_straps();
    logic a;
    for (int k = 0; k < 4; k++) begin
      boot(k[1], k[0]);
      wait_ready();
      chk(own === {1'h0, 1'h1, k[1], k[0], 3'h7}, "own address");
      u_its_i2c_master.set_rate(1300, 600);
      u_its_i2c_master.start();
      u_its_i2c_master.write_byte(abyte(k[1], k[0], 1'h0), a);
      u_its_i2c_master.stop();
      chk(a === 1'b1, "matching address not acked");
      u_its_i2c_master.start();
      u_its_i2c_master.write_byte(abyte(k[1], ~k[0], 1'h0), a);
      u_its_i2c_master.stop();
      chk(a === 1'b0, "foreign address acked");
    end
  endtask
  // fast-mode write across the top slot, sub wraps 0f to 10
  task automatic t_write();
    logic a, all;
    all = 1'b1;
    q_sel.delete();
    q_dat.delete();
    stretch_seen = 1'b0;
    u_its_i2c_master.start();
    u_its_i2c_master.write_byte(abyte(1'h1, 1'h1, 1'h0), a);
    all &= a;
    u_its_i2c_master.write_byte(8'h0f, a);
    all &= a;
    u_its_i2c_master.write_byte(8'ha5, a);
    all &= a;
    u_its_i2c_master.write_byte(8'h3c, a);
    all &= a;
    u_its_i2c_master.stop();
    repeat (20) @(negedge mclk);
    chk(all === 1'b1, "write bytes not acked");
    chk(stretch_seen === 1'b1, "no stretch after data");
    chk(q_sel.size() == 2, "command strobe count");
    if (q_sel.size() == 2) begin
      chk(q_sel[0] === 8'h0f && q_dat[0] === 8'ha5, "first command");
      chk(q_sel[1] === 8'h10 && q_dat[1] === 8'h3c, "second command");
    end
  endtask
  // standard-mode read back through a repeated start
  task automatic t_read();
    logic a, all;
    logic [7:0] d0, d1;
    all = 1'b1;
    stretch_seen = 1'b0;
    u_its_i2c_master.set_rate(5000, T_HIGH_SM_NS);
    u_its_i2c_master.start();
    u_its_i2c_master.write_byte(abyte(1'h1, 1'h1, 1'h0), a);
    all &= a;
    u_its_i2c_master.write_byte(8'h0f, a);
    all &= a;
    u_its_i2c_master.rstart();
    u_its_i2c_master.write_byte(abyte(1'h1, 1'h1, 1'h1), a);
    all &= a;
    u_its_i2c_master.read_byte(d0, 1'b0);
    u_its_i2c_master.read_byte(d1, 1'b1);
    u_its_i2c_master.stop();
    chk(all === 1'b1, "read frame not acked");
    chk(d0 === 8'ha5 && d1 === 8'h3c, "read data");
    chk(stretch_seen === 1'b1, "no stretch before read byte");
  endtask
  // short low phases, so the master must wait out each stretch on the wire
  task automatic t_stretch();
    logic a, all;
    all = 1'b1;
    q_sel.delete();
    q_dat.delete();
    held_seen = 1'b0;
    u_its_i2c_master.set_rate(100, 60);
    u_its_i2c_master.start();
    u_its_i2c_master.write_byte(abyte(1'h1, 1'h1, 1'h0), a);
    all &= a;
    u_its_i2c_master.write_byte(8'h01, a);
    all &= a;
    u_its_i2c_master.write_byte(8'h5a, a);
    all &= a;
    u_its_i2c_master.stop();
    repeat (20) @(negedge mclk);
    chk(all === 1'b1, "short-phase frame not acked");
    chk(held_seen === 1'b1, "scl not held against the master");
    chk(q_sel.size() == 1, "short-phase strobe count");
    if (q_sel.size() == 1) begin
      chk(q_sel[0] === 8'h01 && q_dat[0] === 8'h5a, "short-phase command");
    end
  endtask
  // main sequence, reset and straps move on falling mclk edges only
  initial begin
    rstn = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    stretch_seen = 1'b0;
    sda_seen = 1'b0;
    held_seen = 1'b0;
    t_early();
    t_straps();
    t_write();
    t_read();
    t_stretch();
    chk(m_stuck === 1'b0, "scl held low too long");
    complete_run();
  end
endmodule
